/* core/pcc_pkg.sv */
// Package: constants and types for the performance counter control block
`default_nettype none
package pcc_pkg;
  localparam int CTL_W = 64;
  localparam int CNT_W = 20;
  localparam int C0_LSB = 28;
  localparam int C0_MSB = 47;
  localparam int STALL_BIT = 27;
  localparam int EKILL_BIT = 26;
  localparam int C1_LSB = 6;
  localparam int C1_MSB = 25;
  localparam int RSVD_BIT = 5;
  localparam int STYLE_BIT = 4;
  localparam int SEL_LSB = 2;
  localparam int SEL_MSB = 3;
  localparam int VALID_BIT = 1;
  localparam int TAKEN_BIT = 0;
  localparam int SEXT_LSB = 48;
  localparam int WIN_W = 20;
  localparam int TAG_W = 64;
  localparam int PTE_W = 64;
  localparam int TB_ENTRIES = 32;
  localparam logic [CNT_W-1:0] CNT_RESET = 20'h0_0000;
  localparam logic [WIN_W-1:0] WIN_RESET = 20'h0_0000;
  // Internal register move selectors
  typedef enum logic [2:0]
  {
    PCC_SEL_CTL = 3'h0,
    PCC_SEL_TAG0 = 3'h1,
    PCC_SEL_TAG1 = 3'h2,
    PCC_SEL_PTE0 = 3'h3,
    PCC_SEL_PTE1 = 3'h4
  } pcc_sel_t;
  localparam logic [1:0] SEL_INST_CYC = 2'h0;
  localparam logic [1:0] SEL_CYC_DELAY = 2'h1;
  localparam logic [1:0] SEL_INST_MISS = 2'h2;
  localparam logic [1:0] SEL_CYC_REPLAY = 2'h3;
  // Sampling window state
  typedef enum logic [1:0]
  {
    PCC_WIN_IDLE = 2'b00,
    PCC_WIN_OPEN = 2'b01
  } pcc_win_t;
endpackage : pcc_pkg
`default_nettype wire

/* core/pcc_tb_if.sv */
// Interface: staged write path from the register file into one translation pipe
`default_nettype none
interface pcc_tb_if;
  logic tag_wr;
  logic pte_retire;
  logic [63:0] wdata;
  logic fill_valid;
  logic [4:0] fill_index;
  logic [63:0] fill_tag;
  logic [63:0] fill_pte;
  modport src (output tag_wr, output pte_retire, output wdata,
    input fill_valid, input fill_index, input fill_tag, input fill_pte);
  modport stage (input tag_wr, input pte_retire, input wdata,
    output fill_valid, output fill_index, output fill_tag, output fill_pte);
endinterface : pcc_tb_if
`default_nettype wire

/* core/pcc_tb_stage.sv */
// Tag staging and entry write for one memory pipeline's translation arrays
`default_nettype none
module pcc_tb_stage
#(
  parameter int ENTRIES = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  pcc_tb_if.stage port
);
  import pcc_pkg::*;
  logic [63:0] staged_tag;
  logic [$clog2(ENTRIES)-1:0] rr_ptr;

  // Staging only: the arrays stay untouched until the entry write retires
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      staged_tag <= 64'h0000_0000_0000_0000;
    else if (port.tag_wr)
      staged_tag <= port.wdata;
  end

  // Round-robin allocation of the next entry
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rr_ptr <= '0;
    else if (port.pte_retire)
      rr_ptr <= (rr_ptr == $clog2(ENTRIES)'(ENTRIES - 1)) ? '0 : rr_ptr + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port.fill_valid <= 1'b0;
      port.fill_index <= 5'h0;
      port.fill_tag <= 64'h0000_0000_0000_0000;
      port.fill_pte <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      port.fill_valid <= port.pte_retire;
      if (port.pte_retire)
      begin
        port.fill_index <= 5'(rr_ptr);
        port.fill_tag <= staged_tag;
        port.fill_pte <= port.wdata;
      end
    end
  end
endmodule : pcc_tb_stage
`default_nettype wire

/* core/pcc_top.sv */
// Performance counter control register, counters and translation write staging
//
// Overview of operation
// - Control bits 63..48 read as copies of bit 47; writes there ignored.
// - Counter zero at 47..28 counts when own enable and system or process enable.
// - Aggregate mode: counter zero adds selected event input each cycle.
// - Aggregate overflow of counter zero with irq enable sets pending, raises irq.
// - Sampling mode: counter zero overflow opens window; window overflow interrupts.
// - Bit 27 reports sampled instruction stalled between fetch and map.
// - Bit 26 reports sampled instruction killed in or before map cycle.
// - Counter one at 25..6 counts when own enable and system or process enable.
// - Aggregate overflow of counter one with irq enable sets pending, raises irq.
// - Counter one advances at most one per cycle in both modes.
// - Bit 5 reads zero; writes discarded.
// - Bit 4 selects aggregate (0) or instruction sampling (1) counting.
// - Bits 3..2 pick the event pair feeding both counters.
// - Bit 1 shows sampled non-trapping instruction retired valid.
// - Bit 0 shows sampled conditional branch taken.
// - Each memory pipe has its own tag staging and entry write register.
// - Tag staging write only holds value, arrays unchanged.
// - Retired entry write copies staged tag and entry (tag write data if a tag write coincides), round-robin slot.
// - Process count enable lets a counter run with its own enable set.
`default_nettype none
module pcc_top
#(
  parameter int EVT_W = 4,
  parameter int ENTRIES = pcc_pkg::TB_ENTRIES,
  parameter int WIN_W = pcc_pkg::WIN_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  // Internal register move port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire pcc_pkg::pcc_sel_t reg_sel,
  input wire logic [pcc_pkg::CTL_W-1:0] reg_wdata,
  output logic [pcc_pkg::CTL_W-1:0] reg_rdata,
  // Entry write retirement, per pipe
  input wire logic pte_retire_zero,
  input wire logic pte_retire_one,
  // Enables from fetch control, process context and interrupt enables
  input wire logic counter_zero_enable,
  input wire logic counter_one_enable,
  input wire logic system_count_enable,
  input wire logic process_count_enable,
  input wire logic counter_zero_irq_enable,
  input wire logic counter_one_irq_enable,
  // Event inputs, same clock domain
  input wire logic [EVT_W-1:0] ev_retired,
  input wire logic ev_cycle,
  input wire logic ev_retire_delay,
  input wire logic ev_cache_miss,
  input wire logic ev_replay_trap,
  input wire logic win_tick,
  // Sample status captured from the sampled instruction
  input wire logic sample_load,
  input wire logic sample_stall_in,
  input wire logic sample_early_kill_in,
  input wire logic sample_valid_in,
  input wire logic sample_taken_in,
  // Pending-bit clears from the interrupt summary owner
  input wire logic counter_zero_pending_clr,
  input wire logic counter_one_pending_clr,
  output logic counter_zero_pending,
  output logic counter_one_pending,
  output logic perf_irq,
  // Translation array fill ports
  output logic fill_valid_zero,
  output logic [4:0] fill_index_zero,
  output logic [pcc_pkg::TAG_W-1:0] fill_tag_zero,
  output logic [pcc_pkg::PTE_W-1:0] fill_pte_zero,
  output logic fill_valid_one,
  output logic [4:0] fill_index_one,
  output logic [pcc_pkg::TAG_W-1:0] fill_tag_one,
  output logic [pcc_pkg::PTE_W-1:0] fill_pte_one
);
  import pcc_pkg::*;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  logic [CNT_W-1:0] event_counter_zero;
  logic [CNT_W-1:0] event_counter_one;
  logic count_style_select;
  logic [1:0] input_pair_select;
  logic sample_stall_flag;
  logic sample_early_kill_flag;
  logic sample_retired_valid;
  logic sample_branch_taken;
  logic [WIN_W-1:0] window_count;
  pcc_win_t win_state;

  logic ctl_wr;
  assign ctl_wr = reg_wr && (reg_sel == PCC_SEL_CTL);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_style_select <= 1'b0;
      input_pair_select <= 2'h0;
    end
    else if (ctl_wr)
    begin
      count_style_select <= reg_wdata[STYLE_BIT];
      input_pair_select <= reg_wdata[SEL_MSB:SEL_LSB];
    end
  end

  // ****************************************************************
  // Event selection
  // ****************************************************************
  logic run_zero;
  logic run_one;
  logic [CNT_W-1:0] inc_zero;
  logic inc_one;
  logic sampling;

  assign sampling = count_style_select;
  assign run_zero = counter_zero_enable
                    && (system_count_enable || process_count_enable);
  assign run_one = counter_one_enable
                   && (system_count_enable || process_count_enable);

  always_comb
  begin
    inc_zero = CNT_RESET;
    inc_one = 1'b0;
    case (input_pair_select)
      SEL_INST_CYC:
      begin
        inc_zero = CNT_W'(ev_retired);
        inc_one = ev_cycle;
      end
      SEL_CYC_DELAY:
      begin
        inc_zero = CNT_W'(ev_cycle);
        // Undefined pairing in aggregate mode: counter one counts nothing, counter zero still counts cycles
        inc_one = sampling ? ev_retire_delay : 1'b0;
      end
      SEL_INST_MISS:
      begin
        inc_zero = CNT_W'(ev_retired);
        inc_one = ev_cache_miss;
      end
      SEL_CYC_REPLAY:
      begin
        inc_zero = CNT_W'(ev_cycle);
        inc_one = ev_replay_trap;
      end
      default:
      begin
        inc_zero = CNT_RESET;
        inc_one = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  logic [CNT_W:0] sum_zero;
  logic [CNT_W:0] sum_one;
  logic ovf_zero;
  logic ovf_one;
  logic [WIN_W:0] sum_win;
  logic ovf_win;

  assign sum_zero = {1'b0, event_counter_zero} + {1'b0, inc_zero};
  assign sum_one = {1'b0, event_counter_one} + {{CNT_W{1'b0}}, inc_one};
  assign ovf_zero = run_zero && sum_zero[CNT_W];
  assign ovf_one = run_one && sum_one[CNT_W];
  assign sum_win = {1'b0, window_count} + {{WIN_W{1'b0}}, win_tick};
  assign ovf_win = (win_state == PCC_WIN_OPEN) && sum_win[WIN_W];

  // A write from software wins over counting in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      event_counter_zero <= CNT_RESET;
    else if (ctl_wr)
      event_counter_zero <= reg_wdata[C0_MSB:C0_LSB];
    else if (run_zero)
      event_counter_zero <= sum_zero[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      event_counter_one <= CNT_RESET;
    else if (ctl_wr)
      event_counter_one <= reg_wdata[C1_MSB:C1_LSB];
    else if (run_one)
      event_counter_one <= sum_one[CNT_W-1:0];
  end

  // Sampling window: opened by a counter zero overflow
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_state <= PCC_WIN_IDLE;
      window_count <= WIN_W'(WIN_RESET);
    end
    else if (!sampling)
    begin
      win_state <= PCC_WIN_IDLE;
      window_count <= WIN_W'(WIN_RESET);
    end
    else
    begin
      case (win_state)
        PCC_WIN_IDLE:
          if (ovf_zero)
          begin
            win_state <= PCC_WIN_OPEN;
            window_count <= WIN_W'(WIN_RESET);
          end
        PCC_WIN_OPEN:
        begin
          window_count <= sum_win[WIN_W-1:0];
          if (ovf_win)
            win_state <= PCC_WIN_IDLE;
        end
        default:
          win_state <= PCC_WIN_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pending bits and interrupt
  // ****************************************************************
  logic set_zero;
  logic set_one;
  assign set_zero = counter_zero_irq_enable
                    && (sampling ? ovf_win : ovf_zero);
  assign set_one = counter_one_irq_enable && !sampling && ovf_one;

  // Set wins over clear so an overflow in the clear cycle is not lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter_zero_pending <= 1'b0;
      counter_one_pending <= 1'b0;
    end
    else
    begin
      if (set_zero)
        counter_zero_pending <= 1'b1;
      else if (counter_zero_pending_clr)
        counter_zero_pending <= 1'b0;
      if (set_one)
        counter_one_pending <= 1'b1;
      else if (counter_one_pending_clr)
        counter_one_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      perf_irq <= 1'b0;
    else
      perf_irq <= (counter_zero_pending || set_zero) && !(counter_zero_pending_clr && !set_zero)
                  || (counter_one_pending || set_one) && !(counter_one_pending_clr && !set_one);
  end

  // ****************************************************************
  // Sample status
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_stall_flag <= 1'b0;
      sample_early_kill_flag <= 1'b0;
      sample_retired_valid <= 1'b0;
      sample_branch_taken <= 1'b0;
    end
    else if (sample_load)
    begin
      sample_stall_flag <= sample_stall_in;
      sample_early_kill_flag <= sample_early_kill_in;
      sample_retired_valid <= sample_valid_in;
      sample_branch_taken <= sample_taken_in;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [CTL_W-1:0] ctl_view;
  always_comb
  begin
    ctl_view = '0;
    ctl_view[SEXT_LSB+15:SEXT_LSB] = {16{event_counter_zero[CNT_W-1]}};
    ctl_view[C0_MSB:C0_LSB] = event_counter_zero;
    ctl_view[STALL_BIT] = sample_stall_flag;
    ctl_view[EKILL_BIT] = sample_early_kill_flag;
    ctl_view[C1_MSB:C1_LSB] = event_counter_one;
    ctl_view[RSVD_BIT] = 1'b0;
    ctl_view[STYLE_BIT] = count_style_select;
    ctl_view[SEL_MSB:SEL_LSB] = input_pair_select;
    ctl_view[VALID_BIT] = sample_retired_valid;
    ctl_view[TAKEN_BIT] = sample_branch_taken;
  end

  // Staging and entry registers are write-only and read back as zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 64'h0000_0000_0000_0000;
    else if (reg_rd && reg_sel == PCC_SEL_CTL)
      reg_rdata <= ctl_view;
    else if (reg_rd)
      reg_rdata <= 64'h0000_0000_0000_0000;
  end

  // ****************************************************************
  // Translation write staging, one per memory pipe
  // ****************************************************************
  pcc_tb_if pipe_if [2] ();
  logic [1:0] fill_valid_v;

  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_pipe
      localparam pcc_sel_t TAG_SEL = (p == 0) ? PCC_SEL_TAG0 : PCC_SEL_TAG1;
      localparam pcc_sel_t PTE_SEL = (p == 0) ? PCC_SEL_PTE0 : PCC_SEL_PTE1;
      logic pte_wr_held;
      logic [CTL_W-1:0] pte_data_held;
      logic retire_in;
      assign retire_in = (p == 0) ? pte_retire_zero : pte_retire_one;
      // The entry value waits here until its write retires
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pte_wr_held <= 1'b0;
          pte_data_held <= 64'h0000_0000_0000_0000;
        end
        else if (reg_wr && reg_sel == PTE_SEL)
        begin
          pte_wr_held <= 1'b1;
          pte_data_held <= reg_wdata;
        end
        else if (retire_in)
          pte_wr_held <= 1'b0;
      end
      assign pipe_if[p].tag_wr = reg_wr && (reg_sel == TAG_SEL);
      assign pipe_if[p].pte_retire = retire_in && pte_wr_held;
      assign pipe_if[p].wdata = pipe_if[p].tag_wr ? reg_wdata : pte_data_held;
      pcc_tb_stage #(.ENTRIES(ENTRIES)) u_stage
      (
        .clk(clk),
        .rst_n(rst_n),
        .port(pipe_if[p])
      );
      assign fill_valid_v[p] = pipe_if[p].fill_valid;
    end
  endgenerate

  assign fill_valid_zero = fill_valid_v[0];
  assign fill_index_zero = pipe_if[0].fill_index;
  assign fill_tag_zero = pipe_if[0].fill_tag;
  assign fill_pte_zero = pipe_if[0].fill_pte;
  assign fill_valid_one = fill_valid_v[1];
  assign fill_index_one = pipe_if[1].fill_index;
  assign fill_tag_one = pipe_if[1].fill_tag;
  assign fill_pte_one = pipe_if[1].fill_pte;
endmodule : pcc_top
`default_nettype wire

/* tb/pcc_assertions.sv */
// Port-level assertion checker for the performance counter control block
`default_nettype none
module pcc_assertions
#(
  parameter int ENTRIES = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire pcc_pkg::pcc_sel_t reg_sel,
  input wire logic [pcc_pkg::CTL_W-1:0] reg_rdata,
  input wire logic pte_retire_zero,
  input wire logic pte_retire_one,
  input wire logic counter_one_irq_enable,
  input wire logic counter_zero_pending_clr,
  input wire logic counter_zero_pending,
  input wire logic counter_one_pending,
  input wire logic perf_irq,
  input wire logic fill_valid_zero,
  input wire logic [4:0] fill_index_zero,
  input wire logic fill_valid_one,
  input wire logic [4:0] fill_index_one
);
  import pcc_pkg::*;
  // ************************************************************
  // Round-robin slot tracking, one pointer per pipe
  // ************************************************************
  logic [4:0] rr_zero;
  logic [4:0] rr_one;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rr_zero <= 5'h0;
      rr_one <= 5'h0;
    end
    else
    begin
      if (fill_valid_zero) rr_zero <= (rr_zero == 5'(ENTRIES - 1)) ? 5'h0 : rr_zero + 5'h1;
      if (fill_valid_one) rr_one <= (rr_one == 5'(ENTRIES - 1)) ? 5'h0 : rr_one + 5'h1;
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_read_sign_copy: assert property (
    reg_rd && reg_sel == PCC_SEL_CTL |=> reg_rdata[63:48] == {16{reg_rdata[47]}})
    else $error("control upper bits differ from bit 47");
  chk_reserved_zero: assert property (
    reg_rd && reg_sel == PCC_SEL_CTL |=> !reg_rdata[RSVD_BIT])
    else $error("reserved control bit reads one");
  chk_wo_read_zero: assert property (
    reg_rd && reg_sel inside {PCC_SEL_TAG0, PCC_SEL_TAG1, PCC_SEL_PTE0, PCC_SEL_PTE1}
    |=> reg_rdata == 64'h0) else $error("write-only register reads nonzero");
  chk_fill_cause_zero: assert property (
    fill_valid_zero |-> $past(pte_retire_zero)) else $error("pipe zero fill without retire");
  chk_fill_cause_one: assert property (
    fill_valid_one |-> $past(pte_retire_one)) else $error("pipe one fill without retire");
  chk_rr_slot_order: assert property (
    (fill_valid_zero -> fill_index_zero == rr_zero) && (fill_valid_one -> fill_index_one == rr_one))
    else $error("fill slot out of round-robin order");
  chk_tag_no_fill: assert property (
    reg_wr && reg_sel == PCC_SEL_TAG0 && !pte_retire_zero |=> !fill_valid_zero)
    else $error("tag staging write reached the array");
  chk_irq_follows_pend: assert property (
    perf_irq == (counter_zero_pending || counter_one_pending))
    else $error("interrupt does not match pending bits");
  chk_pend_sticky: assert property (
    counter_zero_pending && !counter_zero_pending_clr |=> counter_zero_pending)
    else $error("pending bit dropped without clear");
  chk_pend_needs_en: assert property (
    $rose(counter_one_pending) |-> $past(counter_one_irq_enable))
    else $error("pending bit set while interrupt disabled");
endmodule // pcc_assertions

bind pcc_top pcc_assertions #(.ENTRIES(ENTRIES)) u_chk
(
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
  .reg_rdata(reg_rdata), .pte_retire_zero(pte_retire_zero), .pte_retire_one(pte_retire_one),
  .counter_one_irq_enable(counter_one_irq_enable),
  .counter_zero_pending_clr(counter_zero_pending_clr),
  .counter_zero_pending(counter_zero_pending), .counter_one_pending(counter_one_pending),
  .perf_irq(perf_irq), .fill_valid_zero(fill_valid_zero), .fill_index_zero(fill_index_zero),
  .fill_valid_one(fill_valid_one), .fill_index_one(fill_index_one)
);
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the performance counter control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pcc_pkg::*;
  typedef struct {string nm; logic [63:0] v;} pcc_exp_t;
  localparam int N_ENT = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  pcc_sel_t reg_sel = PCC_SEL_CTL;
  logic [63:0] reg_wdata = 64'h0;
  logic pte_retire_zero = 1'b0;
  logic pte_retire_one = 1'b0;
  logic [3:0] ens = 4'h0;
  logic [1:0] ies = 2'h0;
  logic [1:0] clrs = 2'h0;
  logic [3:0] ev_retired = 4'h0;
  logic [4:0] evs = 5'h0;
  logic sample_load = 1'b0;
  logic [3:0] smp = 4'h0;
  logic [63:0] reg_rdata, fill_tag_zero, fill_pte_zero, fill_tag_one, fill_pte_one;
  logic counter_zero_pending, counter_one_pending, perf_irq, fill_valid_zero, fill_valid_one;
  logic [4:0] fill_index_zero, fill_index_one;
  logic [19:0] m_c0, m_c1;
  logic [3:0] m_flags;
  logic [1:0] m_sel, m_pend = 2'h0, last_pend = 2'h0;
  logic m_style, rd_seen;
  logic m_open = 1'b0;
  logic [3:0] m_win = 4'h0;
  logic [63:0] d;
  logic [63:0] tp [4];
  int seed = 32'h0000_b359;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  pcc_exp_t exp_q [$];

  pcc_top #(.EVT_W(4), .ENTRIES(N_ENT), .WIN_W(4)) uut
  (
    .clk, .rst_n, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata,
    .pte_retire_zero, .pte_retire_one,
    .counter_zero_enable(ens[3]), .counter_one_enable(ens[2]),
    .system_count_enable(ens[1]), .process_count_enable(ens[0]),
    .counter_zero_irq_enable(ies[1]), .counter_one_irq_enable(ies[0]),
    .ev_retired, .ev_cycle(evs[4]), .ev_retire_delay(evs[3]), .ev_cache_miss(evs[2]),
    .ev_replay_trap(evs[1]), .win_tick(evs[0]), .sample_load,
    .sample_stall_in(smp[3]), .sample_early_kill_in(smp[2]), .sample_valid_in(smp[1]),
    .sample_taken_in(smp[0]), .counter_zero_pending_clr(clrs[1]),
    .counter_one_pending_clr(clrs[0]), .counter_zero_pending, .counter_one_pending, .perf_irq,
    .fill_valid_zero, .fill_index_zero, .fill_tag_zero, .fill_pte_zero,
    .fill_valid_one, .fill_index_one, .fill_tag_one, .fill_pte_one
  );

  always #2.5 clk = ~clk;

  // ************************************************************
  // Drivers and reference model
  // ************************************************************
  function automatic logic [63:0] ctl_view();
    return {{16{m_c0[19]}}, m_c0, m_flags[3:2], m_c1, 1'b0, m_style, m_sel, m_flags[1:0]};
  endfunction

  task automatic expect_v(input string nm, input logic [63:0] v);
    pcc_exp_t e;
    e.nm = nm;
    e.v = v;
    exp_q.push_back(e);
  endtask

  task automatic reg_write(input pcc_sel_t s, input logic [63:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = v;
    if (s == PCC_SEL_CTL)
    begin
      m_c0 = v[47:28];
      m_c1 = v[25:6];
      m_style = v[4];
      m_sel = v[3:2];
      m_open = m_open && v[4];
    end
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input pcc_sel_t s, input logic [63:0] v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_sel = s;
    expect_v("reg_rdata", v);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  task automatic note_pend(input logic [1:0] np);
    if (np != m_pend) expect_v("pending", {61'h0, np, |np});
    m_pend = np;
  endtask

  // Counter writes happen with counting off, so no write-versus-count race is modelled
  task automatic count(input int n, input logic [3:0] e);
    logic [20:0] s0, s1;
    logic [1:0] np;
    logic [4:0] w;
    repeat (n)
    begin
      @(negedge clk);
      ens = e;
      ev_retired = 4'($random(seed));
      evs = 5'($random(seed));
      s0 = {1'b0, m_c0} + (m_sel[0] ? 21'(evs[4]) : 21'(ev_retired));
      s1 = {1'b0, m_c1} + 21'(m_sel == 2'h0 ? evs[4] : m_sel == 2'h1 ? (m_style & evs[3]) :
        evs[4 - int'(m_sel)]);
      np = m_pend;
      // Window ticks run whatever the enables; an open window ignores counter overflow
      if (m_style && m_open)
      begin
        w = {1'b0, m_win} + 5'(evs[0]);
        {m_open, m_win} = {!w[4], w[3:0]};
        if (w[4] && ies[1]) np[1] = 1'b1;
      end
      else if (m_style && e[3] && (e[1] || e[0]) && s0[20])
        {m_open, m_win} = 5'h10;
      if (e[3] && (e[1] || e[0]))
      begin
        m_c0 = s0[19:0];
        if (s0[20] && !m_style && ies[1]) np[1] = 1'b1;
      end
      if (e[2] && (e[1] || e[0]))
      begin
        m_c1 = s1[19:0];
        if (s1[20] && !m_style && ies[0]) np[0] = 1'b1;
      end
      note_pend(np);
    end
    @(negedge clk);
    ens = 4'h0;
    // Frozen ticks keep the window still while registers are written or read
    evs = 5'h0;
  endtask

  task automatic pulse_io(input bit retire);
    @(negedge clk);
    if (retire) {pte_retire_zero, pte_retire_one} = 2'b11;
    else clrs = 2'b11;
    if (!retire) note_pend(2'h0);
    @(negedge clk);
    {pte_retire_zero, pte_retire_one, clrs} = 4'h0;
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ************************************************************
  // Result monitor
  // ************************************************************
  task automatic check_pop(input string nm, input logic [63:0] v);
    pcc_exp_t e;
    checks++;
    if (exp_q.size() == 0)
    begin
      miscompares++;
      $display("ERROR %s expected nothing seen %h", nm, v);
    end
    else
    begin
      e = exp_q.pop_front();
      if (e.v !== v)
      begin
        miscompares++;
        $display("ERROR %s expected %h (%s) seen %h", nm, e.v, e.nm, v);
      end
    end
  endtask

  always @(posedge clk)
  begin
    rd_seen = reg_rd;
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      tally_and_finish();
    end
    #1;
    if (rd_seen) check_pop("reg_rdata", reg_rdata);
    if ({counter_zero_pending, counter_one_pending} !== last_pend)
    begin
      last_pend = {counter_zero_pending, counter_one_pending};
      check_pop("pending", {61'h0, last_pend, perf_irq});
    end
    if (fill_valid_zero === 1'b1)
    begin
      check_pop("fill_index_zero", 64'(fill_index_zero));
      check_pop("fill_tag_zero", fill_tag_zero);
      check_pop("fill_pte_zero", fill_pte_zero);
    end
    if (fill_valid_one === 1'b1)
    begin
      check_pop("fill_index_one", 64'(fill_index_one));
      check_pop("fill_tag_one", fill_tag_one);
      check_pop("fill_pte_one", fill_pte_one);
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      smp = 4'($random(seed));
      sample_load = 1'b1;
      m_flags = smp;
      @(negedge clk);
      sample_load = 1'b0;
      d = (i == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : {$random(seed), $random(seed)};
      reg_write(PCC_SEL_CTL, d);
      reg_read(PCC_SEL_CTL, ctl_view());
    end
    for (int s = 1; s < 5; s++) reg_read(pcc_sel_t'(s), 64'h0);
    // A narrow window lets sampling runs reach the window overflow interrupt
    for (int m = 0; m < 32; m++)
    begin
      d = {$random(seed), $random(seed)};
      d[47:44] = 4'h0;
      if (m[0]) d[47:28] = 20'hF_FFF0;
      d[25:6] = 20'hF_FFF8;
      d[4:2] = m[4:2];
      ies = 2'($random(seed));
      reg_write(PCC_SEL_CTL, d);
      count(40, m[1] ? 4'hF : 4'($random(seed)));
      reg_read(PCC_SEL_CTL, ctl_view());
      pulse_io(1'b0);
    end
    for (int i = 0; i < N_ENT + 2; i++)
    begin
      for (int k = 0; k < 4; k++) tp[k] = {$random(seed), $random(seed)};
      for (int k = 0; k < 4; k++) reg_write(pcc_sel_t'(k + 1), tp[k]);
      expect_v("fill_index_zero", 64'(i % N_ENT));
      expect_v("fill_tag_zero", tp[0]);
      expect_v("fill_pte_zero", tp[2]);
      expect_v("fill_index_one", 64'(i % N_ENT));
      expect_v("fill_tag_one", tp[1]);
      expect_v("fill_pte_one", tp[3]);
      pulse_io(1'b1);
    end
    pulse_io(1'b1);
    repeat (4) @(negedge clk);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
